// ---- hw/ses_status_top.sv ----
// status reporting block: four 16-bit register sets, the 8-bit standard
// event set, the summary status byte, its service-request mask and
// service-request generation toward the bus controller.
// assumes a command parser issues one-cycle commands and a bus interface
// raises spoll_req for one cycle when the controller serial-polls.
// limitation: a rise while a request waits is not remembered.
// the request line is a level held until the poll.
//
// Notes on behaviour
// - status byte and standard events are 8 bits; others 16, bit 15 zero.
// - condition bits follow their condition live and are read only.
// - rising condition sets the event bit only with positive filter set.
// - falling condition sets the event bit only with negative filter set.
// - both filters set means either direction of change is reported.
// - event bits stay set until the event register is cleared.
// - reading an event register clears all its bits.
// - clear status command clears every event register together.
// - summary is the or of enabled event bits; enables read and write.
// - a rising enabled byte bit starts a request only if none pending.
// - a request stays pending until the controller serial-polls.
// - starting a request drives the request line and sets the flag.
// - serial poll returns the byte, then clears only the request flag.
// - bit 6 gives request flag on poll, master summary on query.
// - byte acts as a condition register; mask bit 6 always reads 0.
// - byte bit 0 sums user events, bit 2 device state events.
// - byte bit 3 sums questionable events, bit 5 standard events.
// - byte bit 4 is set while the output queue holds a message.
// - master summary flag is one when any enabled byte bit is one.
// - byte bit 7 sums the standard operation events.
`timescale 1ns/1ps
module ses_status_top #(
  parameter int SET_WIDTH = ses_pkg::SET_W,
  parameter int EVT_WIDTH = ses_pkg::BYTE_W
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [SET_WIDTH-1:0] user_cond,
  input wire logic [SET_WIDTH-1:0] devst_cond,
  input wire logic [SET_WIDTH-1:0] quest_cond,
  input wire logic [SET_WIDTH-1:0] oper_cond,
  input wire logic [EVT_WIDTH-1:0] std_event_in,
  input wire logic msg_avail,
  input wire logic cmd_valid,
  input wire ses_pkg::ses_cmd_s cmd,
  output logic rsp_valid,
  output logic [SET_WIDTH-1:0] rsp_data,
  input wire logic spoll_req,
  output logic spoll_valid,
  output logic [7:0] spoll_data,
  output logic srq,
  output logic request_service_flag,
  output logic master_summary_flag
);

  // wide sets take codes 0 to 3, standard events code 4
  localparam int NS = ses_pkg::NUM_SETS;

  // true when a valid command of the given op addresses the given set
  function automatic logic hit(input logic v, input ses_pkg::ses_cmd_s c,
                               input ses_pkg::ses_op_e op, input logic [2:0] s);
    hit = v && (c.op == op) && (c.set == s);
  endfunction

  // per-set views, indexed by the set field
  logic [NS-1:0][SET_WIDTH-1:0] cond_a;
  logic [NS-1:0][SET_WIDTH-1:0] ptr_a;
  logic [NS-1:0][SET_WIDTH-1:0] ntr_a;
  logic [NS-1:0][SET_WIDTH-1:0] ena_a;
  logic [NS-1:0][SET_WIDTH-1:0] evt_a;
  logic [NS-1:0] sum_a;
  wire [NS-2:0][SET_WIDTH-1:0] wide_cond;
  wire cls_w;
  logic [7:0] sre_q;
  logic [7:0] stb_prev_q;
  logic pending_q;
  logic rsp_valid_q;
  logic [SET_WIDTH-1:0] rsp_data_q;
  logic spoll_valid_q;
  logic [7:0] spoll_data_q;
  wire [7:0] stb_cond;
  wire [7:0] stb_rise;
  wire srq_start;
  wire mss_w;
  wire set_ok;
  wire [SET_WIDTH-1:0] rd_mux;
  wire [7:0] stb_query;
  wire [7:0] stb_poll;

  // condition buses gathered for the generate loop
  assign wide_cond[ses_pkg::SET_USER] = user_cond;
  assign wide_cond[ses_pkg::SET_DEVST] = devst_cond;
  assign wide_cond[ses_pkg::SET_QUEST] = quest_cond;
  assign wide_cond[ses_pkg::SET_OPER] = oper_cond;
  assign cls_w = cmd_valid && (cmd.op == ses_pkg::OP_CLS);

  // four general 16-bit sets with full transition filters
  for (genvar g = 0; g < NS - 1; g++) begin : g_wide
    ses_reg_set #(
      .WIDTH(SET_WIDTH),
      .ZERO_MSB(1'b1),
      .FIXED_PTR(1'b0)
    ) u_set (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .cond_in(wide_cond[g]),
      .wr_ptr(hit(cmd_valid, cmd, ses_pkg::OP_WR_PTR, 3'(g))),
      .wr_ntr(hit(cmd_valid, cmd, ses_pkg::OP_WR_NTR, 3'(g))),
      .wr_ena(hit(cmd_valid, cmd, ses_pkg::OP_WR_ENA, 3'(g))),
      .wr_data(cmd.data),
      .rd_clr(hit(cmd_valid, cmd, ses_pkg::OP_RD_EVENT, 3'(g))),
      .cls(cls_w),
      .cond_out(cond_a[g]),
      .ptr_out(ptr_a[g]),
      .ntr_out(ntr_a[g]),
      .ena_out(ena_a[g]),
      .event_out(evt_a[g]),
      .summary(sum_a[g])
    );
  end

  // standard event outputs, widened below
  logic [EVT_WIDTH-1:0] se_cond;
  logic [EVT_WIDTH-1:0] se_ptr;
  logic [EVT_WIDTH-1:0] se_ntr;
  logic [EVT_WIDTH-1:0] se_ena;
  logic [EVT_WIDTH-1:0] se_evt;

  // standard events: 8 bits, every rising input is latched, no filters
  ses_reg_set #(
    .WIDTH(EVT_WIDTH),
    .ZERO_MSB(1'b0),
    .FIXED_PTR(1'b1)
  ) u_std_event (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cond_in(std_event_in),
    .wr_ptr(1'b0),
    .wr_ntr(1'b0),
    .wr_ena(hit(cmd_valid, cmd, ses_pkg::OP_WR_ENA, ses_pkg::SET_STDEV)),
    .wr_data(cmd.data[EVT_WIDTH-1:0]),
    .rd_clr(hit(cmd_valid, cmd, ses_pkg::OP_RD_EVENT, ses_pkg::SET_STDEV)),
    .cls(cls_w),
    .cond_out(se_cond),
    .ptr_out(se_ptr),
    .ntr_out(se_ntr),
    .ena_out(se_ena),
    .event_out(se_evt),
    .summary(sum_a[ses_pkg::SET_STDEV])
  );

  // narrow set widened so one read mux serves all five sets
  assign cond_a[ses_pkg::SET_STDEV] = SET_WIDTH'(se_cond);
  assign ptr_a[ses_pkg::SET_STDEV] = SET_WIDTH'(se_ptr);
  assign ntr_a[ses_pkg::SET_STDEV] = SET_WIDTH'(se_ntr);
  assign ena_a[ses_pkg::SET_STDEV] = SET_WIDTH'(se_ena);
  assign evt_a[ses_pkg::SET_STDEV] = SET_WIDTH'(se_evt);

  // summary status byte as a live condition register, bit 6 held apart
  assign stb_cond[ses_pkg::STB_USER] = sum_a[ses_pkg::SET_USER];
  assign stb_cond[1] = 1'b0;
  assign stb_cond[ses_pkg::STB_DEVST] = sum_a[ses_pkg::SET_DEVST];
  assign stb_cond[ses_pkg::STB_QUEST] = sum_a[ses_pkg::SET_QUEST];
  assign stb_cond[ses_pkg::STB_MAV] = msg_avail;
  assign stb_cond[ses_pkg::STB_STDEV] = sum_a[ses_pkg::SET_STDEV];
  assign stb_cond[ses_pkg::STB_RQS] = 1'b0;
  assign stb_cond[ses_pkg::STB_OPER] = sum_a[ses_pkg::SET_OPER];

  // master summary and request start; mask bit 6 is zero so never counts
  assign mss_w = |(stb_cond & sre_q);
  assign stb_rise = stb_cond & ~stb_prev_q & sre_q;
  // a rise while a request waits is dropped, not queued behind the poll
  assign srq_start = (|stb_rise) && !pending_q;
  assign stb_query = {stb_cond[7], mss_w, stb_cond[5:0]};
  assign stb_poll = {stb_cond[7], pending_q, stb_cond[5:0]};

  // command read data; unknown sets and write ops answer zero
  // byte and mask ops ignore the set field
  assign set_ok = cmd.set < 3'(NS);
  assign rd_mux =
    (cmd.op == ses_pkg::OP_RD_STB) ? SET_WIDTH'(stb_query) :
    (cmd.op == ses_pkg::OP_RD_SRE) ? SET_WIDTH'(sre_q) :
    !set_ok ? '0 :
    (cmd.op == ses_pkg::OP_RD_COND) ? cond_a[cmd.set] :
    (cmd.op == ses_pkg::OP_RD_EVENT) ? evt_a[cmd.set] :
    (cmd.op == ses_pkg::OP_RD_PTR) ? ptr_a[cmd.set] :
    (cmd.op == ses_pkg::OP_RD_NTR) ? ntr_a[cmd.set] :
    (cmd.op == ses_pkg::OP_RD_ENA) ? ena_a[cmd.set] : '0;

  // service-request mask and edge history of the byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sre_q <= ses_pkg::SRE_RESET;
      stb_prev_q <= '0;
    end else begin
      stb_prev_q <= stb_cond;
      // bit 6 is masked before it lands, so it reads back 0
      if (cmd_valid && cmd.op == ses_pkg::OP_WR_SRE) sre_q <= cmd.data[7:0] & ses_pkg::SRE_WR_MASK;
    end
  end

  // pending request; the poll clears only this flag
  // a start in a poll cycle wins; that poll found no request
  always_ff @(posedge core_clk) begin
    if (!reset_n) pending_q <= 1'b0;
    else if (srq_start) pending_q <= 1'b1;
    else if (spoll_req) pending_q <= 1'b0;
  end

  // registered answers to commands and serial polls
  // data words hold until the next request for slow readers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      spoll_valid_q <= 1'b0;
      spoll_data_q <= '0;
    end else begin
      rsp_valid_q <= cmd_valid;
      rsp_data_q <= cmd_valid ? rd_mux : rsp_data_q;
      spoll_valid_q <= spoll_req;
      spoll_data_q <= spoll_req ? stb_poll : spoll_data_q;
    end
  end

  // all outputs from flops except the live master summary
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign spoll_valid = spoll_valid_q;
  assign spoll_data = spoll_data_q;
  assign srq = pending_q;
  assign request_service_flag = pending_q;
  assign master_summary_flag = mss_w;

  // request start and hold
  a_srq_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((|stb_rise) && !pending_q) |=> (srq && request_service_flag))
    else $error("enabled summary rise did not start a service request");
  a_srq_no_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(srq) |-> ($past(stb_rise) != 8'h00))
    else $error("service request started without an enabled rise");
  a_srq_pending: assert property (@(posedge core_clk) disable iff (!reset_n)
    (srq && !spoll_req) |=> srq)
    else $error("pending service request dropped before serial poll");

  // serial poll answer
  a_poll_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    (srq && spoll_req) |=> (!srq && spoll_valid && spoll_data[ses_pkg::STB_RQS]))
    else $error("serial poll did not return and clear the request flag");
  a_poll_other_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    spoll_req |=> (spoll_data[5:0] == $past(stb_cond[5:0])) && (spoll_data[7] == $past(stb_cond[7])))
    else $error("serial poll byte lost other status bits");

  // byte query and mask
  a_query_mss: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd.op == ses_pkg::OP_RD_STB) |=> (rsp_data[ses_pkg::STB_RQS] == $past(mss_w)))
    else $error("status query bit 6 is not the master summary");
  a_mask_bit6: assert property (@(posedge core_clk) disable iff (!reset_n)
    sre_q[ses_pkg::STB_RQS] == 1'b0)
    else $error("service request mask bit 6 is set");

  // summary and queue bits
  a_mss_or: assert property (@(posedge core_clk) disable iff (!reset_n)
    master_summary_flag == ((stb_cond & sre_q) != 8'h00))
    else $error("master summary flag differs from enabled byte bits");
  a_msg_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd.op == ses_pkg::OP_RD_STB) |=> (rsp_data[ses_pkg::STB_MAV] == $past(msg_avail)))
    else $error("message available bit does not follow the queue");

  // request and answer side
  a_no_start_masked: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!srq && stb_rise == 8'h00) |=> !srq)
    else $error("request rose with no enabled rise");
  a_poll_bit6: assert property (@(posedge core_clk) disable iff (!reset_n)
    spoll_req |=> (spoll_valid && spoll_data[ses_pkg::STB_RQS] == $past(srq)))
    else $error("poll bit 6 is not the request flag");
  a_sre_write: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd.op == ses_pkg::OP_WR_SRE) |=> (sre_q == ($past(cmd.data[7:0]) & ses_pkg::SRE_WR_MASK)))
    else $error("mask write lost");
  a_rsp_strobe: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_valid |=> rsp_valid)
    else $error("command without response strobe");
  // byte query read path and the width rule
  a_query_oper: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cmd_valid && cmd.op == ses_pkg::OP_RD_STB) |=> rsp_data[ses_pkg::STB_OPER] == $past(sum_a[ses_pkg::SET_OPER]))
    else $error("query bit 7 lost the operation sum");
  a_rsp_msb: assert property (@(posedge core_clk) disable iff (!reset_n)
    rsp_valid |-> (rsp_data[SET_WIDTH-1] == 1'b0))
    else $error("top bit of a response is set");
  // no disable here, so the reset cycles are seen
  a_reset_clears: assert property (@(posedge core_clk) !reset_n |=>
    (!srq && !rsp_valid && !spoll_valid))
    else $error("reset left a request or strobe");

  // main scenarios worth seeing
  c_srq_start: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(srq));
  c_poll_clear: cover property (@(posedge core_clk) disable iff (!reset_n) srq && spoll_req);
  c_clear_status: cover property (@(posedge core_clk) disable iff (!reset_n) cls_w && sum_a != '0);
  c_rise_blocked: cover property (@(posedge core_clk) disable iff (!reset_n) (|stb_rise) && pending_q);
  c_mss_query: cover property (@(posedge core_clk) disable iff (!reset_n) cmd_valid && cmd.op == ses_pkg::OP_RD_STB && mss_w);

endmodule // ses_status_top

// ---- hw/ses_pkg.sv ----
// status/event/service-request package: register set ids, bit positions,
// reset values and the command carrier shared by the status block files.
// assumes a command parser upstream that turns bus messages into commands.
package ses_pkg;

  localparam int SET_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEL_W = 3;

  // register set selectors
  localparam logic [2:0] SET_USER = 3'h0;
  localparam logic [2:0] SET_DEVST = 3'h1;
  localparam logic [2:0] SET_QUEST = 3'h2;
  localparam logic [2:0] SET_OPER = 3'h3;
  localparam logic [2:0] SET_STDEV = 3'h4;
  localparam int NUM_SETS = 5;

  // summary status byte bit positions
  localparam int STB_USER = 0;
  localparam int STB_DEVST = 2;
  localparam int STB_QUEST = 3;
  localparam int STB_MAV = 4;
  localparam int STB_STDEV = 5;
  localparam int STB_RQS = 6;
  localparam int STB_OPER = 7;

  // values after reset
  localparam logic [15:0] PTR_RESET = 16'hFFFF;
  localparam logic [15:0] NTR_RESET = 16'h0000;
  localparam logic [15:0] ENA_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] SRE_WR_MASK = 8'hBF;

  typedef enum logic [3:0] {
    OP_RD_COND,
    OP_RD_EVENT,
    OP_RD_PTR,
    OP_WR_PTR,
    OP_RD_NTR,
    OP_WR_NTR,
    OP_RD_ENA,
    OP_WR_ENA,
    OP_CLS,
    OP_RD_STB,
    OP_RD_SRE,
    OP_WR_SRE
  } ses_op_e;

  typedef struct packed {
    ses_op_e op;
    logic [2:0] set;
    logic [15:0] data;
  } ses_cmd_s;

endpackage

// ---- hw/ses_reg_set.sv ----
// one status register set: condition, transition filters, sticky event,
// enable mask and summary bit.
// assumes condition inputs are synchronous to core_clk.
`timescale 1ns/1ps
module ses_reg_set #(
  parameter int WIDTH = 16,
  parameter bit ZERO_MSB = 1'b1,
  parameter bit FIXED_PTR = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] cond_in,
  input wire logic wr_ptr,
  input wire logic wr_ntr,
  input wire logic wr_ena,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_clr,
  input wire logic cls,
  output logic [WIDTH-1:0] cond_out,
  output logic [WIDTH-1:0] ptr_out,
  output logic [WIDTH-1:0] ntr_out,
  output logic [WIDTH-1:0] ena_out,
  output logic [WIDTH-1:0] event_out,
  output logic summary
);

  localparam logic [WIDTH-1:0] ALL1 = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] MASK = ZERO_MSB ? {1'b0, {(WIDTH-1){1'b1}}} : ALL1;

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] ptr_q;
  logic [WIDTH-1:0] ntr_q;
  logic [WIDTH-1:0] ena_q;
  logic [WIDTH-1:0] event_q;
  logic [WIDTH-1:0] event_d;
  wire [WIDTH-1:0] cond_w;
  wire [WIDTH-1:0] ptr_eff;
  wire [WIDTH-1:0] ntr_eff;
  wire [WIDTH-1:0] pos_w;
  wire [WIDTH-1:0] neg_w;
  wire [WIDTH-1:0] new_evt;

  // condition passes straight through, top bit forced low on wide sets
  assign cond_w = cond_in & MASK;
  // a fixed filter reports every rising edge, used for the standard events
  assign ptr_eff = FIXED_PTR ? MASK : ptr_q;
  assign ntr_eff = FIXED_PTR ? '0 : ntr_q;
  assign pos_w = cond_w & ~prev_q & ptr_eff;
  assign neg_w = ~cond_w & prev_q & ntr_eff;
  assign new_evt = pos_w | neg_w;
  // a new event in the clearing cycle survives the clear
  assign event_d = ((rd_clr | cls) ? '0 : event_q) | new_evt;

  // edge history and sticky events
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prev_q <= '0;
      event_q <= '0;
    end else begin
      prev_q <= cond_w;
      event_q <= event_d;
    end
  end

  // software-written filters and enable
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ptr_q <= ses_pkg::PTR_RESET[WIDTH-1:0] & MASK;
      ntr_q <= ses_pkg::NTR_RESET[WIDTH-1:0];
      ena_q <= ses_pkg::ENA_RESET[WIDTH-1:0];
    end else begin
      if (wr_ptr && !FIXED_PTR) ptr_q <= wr_data & MASK;
      if (wr_ntr && !FIXED_PTR) ntr_q <= wr_data & MASK;
      if (wr_ena) ena_q <= wr_data & MASK;
    end
  end

  assign cond_out = cond_w;
  assign ptr_out = ptr_eff;
  assign ntr_out = ntr_eff;
  assign ena_out = ena_q;
  assign event_out = event_q;
  assign summary = |(event_q & ena_q);

  a_pos_edge_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
    (pos_w != '0) |=> ((event_q & $past(pos_w)) == $past(pos_w)))
    else $error("enabled rising condition did not set its event bit");
  a_neg_edge_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
    (neg_w != '0) |=> ((event_q & $past(neg_w)) == $past(neg_w)))
    else $error("enabled falling condition did not set its event bit");
  a_event_no_spur: assert property (@(posedge core_clk) disable iff (!reset_n)
    1'b1 |=> ((event_q & ~$past(event_q) & ~$past(new_evt)) == '0))
    else $error("event bit set without a filtered transition");
  a_event_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!rd_clr && !cls) |=> ((event_q & $past(event_q)) == $past(event_q)))
    else $error("event bit dropped without a clear");
  a_read_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((rd_clr || cls) && new_evt == '0) |=> (event_q == '0))
    else $error("event register not cleared by read or clear status");
  a_summary_or: assert property (@(posedge core_clk) disable iff (!reset_n)
    summary == ((event_q & ena_q) != '0))
    else $error("summary bit differs from enabled event or");
  a_msb_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    ((cond_out | event_out | ena_out) & ~MASK) == '0)
    else $error("top bit of a wide set is not zero");

endmodule // ses_reg_set

// ---- dv/ses_poll_ctrl.sv ----
// behavioural bus controller that serial-polls the status block whenever srq is up.
// assumes one core_clk domain; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
module ses_poll_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic srq,
  input wire logic spoll_valid,
  input wire logic [7:0] spoll_data,
  input wire logic poll_en,
  input wire logic [7:0] poll_delay,
  output logic spoll_req,
  output logic [7:0] last_byte
);
  // poll after a chosen latency so prompt and slow controllers are both covered
  initial begin
    spoll_req = 1'b0;
    last_byte = 8'h00;
    forever begin
      // looked at on the edge, so a bench change 1 ns later counts next cycle
      @(posedge core_clk);
      if (reset_n === 1'b1 && poll_en === 1'b1 && srq === 1'b1) begin
        repeat (poll_delay) @(posedge core_clk);
        #1;
        spoll_req = 1'b1;
        @(posedge core_clk);
        #1;
        spoll_req = 1'b0;
        // the byte is held until the next poll, so taking it here is safe
        if (spoll_valid === 1'b1) begin
          last_byte = spoll_data;
        end
      end
    end
  end
endmodule // ses_poll_ctrl

// ---- dv/test_ses_status_top.sv ----
// self-checking bench for the status block with a serial-polling controller model.
// assumes ses_pkg and ses_status_top are compiled first; inputs move 1 ns after a rising edge.
`timescale 1ns/1ps
module test_ses_status_top;
  logic core_clk;
  logic reset_n;
  logic [15:0] user_cond, devst_cond, quest_cond, oper_cond, rsp_data, r;
  logic [7:0] std_event_in, spoll_data, last_byte, poll_delay;
  logic msg_avail, cmd_valid, rsp_valid, spoll_req, spoll_valid, srq;
  logic request_service_flag, master_summary_flag, poll_en;
  ses_pkg::ses_cmd_s cmd;
  int n_mismatch;
  int n_tests;

  ses_status_top ses_status_top_i (.core_clk(core_clk), .reset_n(reset_n), .user_cond(user_cond),
    .devst_cond(devst_cond), .quest_cond(quest_cond), .oper_cond(oper_cond), .std_event_in(std_event_in),
    .msg_avail(msg_avail), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .spoll_req(spoll_req), .spoll_valid(spoll_valid), .spoll_data(spoll_data), .srq(srq),
    .request_service_flag(request_service_flag), .master_summary_flag(master_summary_flag));
  ses_poll_ctrl ses_poll_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .srq(srq), .spoll_valid(spoll_valid),
    .spoll_data(spoll_data), .poll_en(poll_en), .poll_delay(poll_delay), .spoll_req(spoll_req),
    .last_byte(last_byte));

  // 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // comparison and verdict helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one command per call; the answer must be there 1 ns after the taking edge
  task automatic do_cmd(input ses_pkg::ses_op_e op, input logic [2:0] s, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op: op, set: s, data: d};
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    check({15'h0000, rsp_valid}, 16'h0001, "response strobe");
    r = rsp_data;
  endtask
  task automatic rd_chk(input ses_pkg::ses_op_e op, input logic [2:0] s, input logic [15:0] exp);
    do_cmd(op, s, 16'h0000);
    check(r, exp, "read data");
  endtask

  // srq watchers; a wait that runs out ends the run
  task automatic wait_srq(input logic v, input int bound);
    int i;
    for (i = 0; i < bound && srq !== v; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (srq !== v) begin
      n_mismatch++;
      $display("wrong value at %0t: srq never reached %b", $time, v);
      wrap_up();
    end
  endtask
  task automatic hold_srq(input logic v, input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      check({15'h0000, srq}, {15'h0000, v}, "srq level");
    end
  endtask

  task automatic set_cond(input logic [2:0] s, input logic [15:0] v);
    case (s)
      3'h0: user_cond = v;
      3'h1: devst_cond = v;
      3'h2: quest_cond = v;
      default: oper_cond = v;
    endcase
  endtask
  function automatic logic [15:0] stb_bit(input logic [2:0] s);
    case (s)
      3'h0: stb_bit = 16'h0001;
      3'h1: stb_bit = 16'h0004;
      3'h2: stb_bit = 16'h0008;
      default: stb_bit = 16'h0080;
    endcase
  endfunction
  task automatic apply_reset(input int n);
    reset_n = 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
  endtask

  // scenarios
  task automatic t_reset();
    rd_chk(ses_pkg::OP_RD_PTR, ses_pkg::SET_USER, 16'h7FFF);
    rd_chk(ses_pkg::OP_RD_NTR, ses_pkg::SET_QUEST, 16'h0000);
    rd_chk(ses_pkg::OP_RD_PTR, ses_pkg::SET_STDEV, 16'h00FF);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_DEVST, 16'h0000);
    rd_chk(ses_pkg::OP_RD_COND, 3'h5, 16'h0000);
    check({15'h0000, srq}, 16'h0000, "srq after reset");
    $display("test reset done");
  endtask
  task automatic t_filters();
    set_cond(3'h0, 16'h0008);
    rd_chk(ses_pkg::OP_RD_COND, ses_pkg::SET_USER, 16'h0008);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_USER, 16'h0008);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_USER, 16'h0000);
    set_cond(3'h0, 16'hFFFF);
    rd_chk(ses_pkg::OP_RD_COND, ses_pkg::SET_USER, 16'h7FFF);
    set_cond(3'h0, 16'h0000);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_USER, 16'h7FF7);
    do_cmd(ses_pkg::OP_WR_PTR, ses_pkg::SET_QUEST, 16'h0000);
    do_cmd(ses_pkg::OP_WR_NTR, ses_pkg::SET_QUEST, 16'hFFFF);
    rd_chk(ses_pkg::OP_RD_NTR, ses_pkg::SET_QUEST, 16'h7FFF);
    set_cond(3'h2, 16'h0004);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_QUEST, 16'h0000);
    set_cond(3'h2, 16'h0000);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_QUEST, 16'h0004);
    do_cmd(ses_pkg::OP_WR_PTR, ses_pkg::SET_QUEST, 16'h0004);
    set_cond(3'h2, 16'h0004);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_QUEST, 16'h0004);
    set_cond(3'h2, 16'h0000);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_QUEST, 16'h0004);
    $display("test filters done");
  endtask
  task automatic t_cls();
    logic [2:0] s;
    set_cond(3'h0, 16'h0001);
    set_cond(3'h1, 16'h0001);
    std_event_in = 8'h01;
    @(posedge core_clk);
    #1;
    std_event_in = 8'h00;
    do_cmd(ses_pkg::OP_CLS, 3'h0, 16'h0000);
    for (s = 3'h0; s < 3'h5; s++) begin
      rd_chk(ses_pkg::OP_RD_EVENT, s, 16'h0000);
    end
    set_cond(3'h0, 16'h0000);
    set_cond(3'h1, 16'h0000);
    $display("test clear status done");
  endtask
  // the mask is still 0 here, so no service request may start
  task automatic t_summary();
    logic [2:0] s;
    for (s = 3'h0; s < 3'h4; s++) begin
      set_cond(s, 16'h0004);
      do_cmd(ses_pkg::OP_WR_ENA, s, 16'h0004);
      rd_chk(ses_pkg::OP_RD_ENA, s, 16'h0004);
      rd_chk(ses_pkg::OP_RD_STB, 3'h0, stb_bit(s));
      rd_chk(ses_pkg::OP_RD_EVENT, s, 16'h0004);
      rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0000);
      do_cmd(ses_pkg::OP_WR_ENA, s, 16'h0000);
      set_cond(s, 16'h0000);
    end
    std_event_in = 8'h80;
    @(posedge core_clk);
    #1;
    std_event_in = 8'h00;
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0000);
    do_cmd(ses_pkg::OP_WR_ENA, ses_pkg::SET_STDEV, 16'h0080);
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0020);
    rd_chk(ses_pkg::OP_RD_EVENT, ses_pkg::SET_STDEV, 16'h0080);
    do_cmd(ses_pkg::OP_WR_ENA, ses_pkg::SET_STDEV, 16'h0000);
    $display("test summary done");
  endtask
  task automatic t_srq_msg();
    poll_delay = 8'h00;
    poll_en = 1'b1;
    do_cmd(ses_pkg::OP_WR_SRE, 3'h0, 16'h00FF);
    rd_chk(ses_pkg::OP_RD_SRE, 3'h0, 16'h00BF);
    msg_avail = 1'b1;
    wait_srq(1'b1, 4);
    wait_srq(1'b0, 6);
    hold_srq(1'b0, 2);
    check({8'h00, last_byte}, 16'h0050, "polled byte");
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0050);
    check({15'h0000, master_summary_flag}, 16'h0001, "summary flag");
    msg_avail = 1'b0;
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0000);
    $display("test message request done");
  endtask
  // a second enabled rise while pending must be dropped; reset mid-run clears the request
  task automatic t_srq_pending();
    poll_en = 1'b0;
    do_cmd(ses_pkg::OP_WR_SRE, 3'h0, 16'h0005);
    do_cmd(ses_pkg::OP_WR_ENA, ses_pkg::SET_USER, 16'h0002);
    do_cmd(ses_pkg::OP_WR_ENA, ses_pkg::SET_DEVST, 16'h0002);
    set_cond(3'h0, 16'h0002);
    wait_srq(1'b1, 4);
    check({15'h0000, request_service_flag}, 16'h0001, "request flag");
    set_cond(3'h1, 16'h0002);
    hold_srq(1'b1, 8);
    poll_delay = 8'h05;
    poll_en = 1'b1;
    wait_srq(1'b0, 12);
    poll_en = 1'b0;
    hold_srq(1'b0, 4);
    check({8'h00, last_byte}, 16'h0045, "polled byte");
    check({15'h0000, request_service_flag}, 16'h0000, "request flag");
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0045);
    do_cmd(ses_pkg::OP_CLS, 3'h0, 16'h0000);
    set_cond(3'h0, 16'h0000);
    rd_chk(ses_pkg::OP_RD_STB, 3'h0, 16'h0000);
    set_cond(3'h0, 16'h0002);
    wait_srq(1'b1, 4);
    apply_reset(2);
    check({15'h0000, srq}, 16'h0000, "srq after reset");
    rd_chk(ses_pkg::OP_RD_SRE, 3'h0, 16'h0000);
    $display("test pending request done");
  endtask

  // main sequence
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {user_cond, devst_cond, quest_cond, oper_cond} = 64'h0000_0000_0000_0000;
    std_event_in = 8'h00;
    msg_avail = 1'b0;
    cmd_valid = 1'b0;
    cmd = '{op: ses_pkg::OP_RD_COND, set: 3'h0, data: 16'h0000};
    poll_en = 1'b0;
    poll_delay = 8'h00;
    r = 16'h0000;
    apply_reset(4);
    t_reset();
    t_filters();
    t_cls();
    t_summary();
    t_srq_msg();
    t_srq_pending();
    wrap_up();
  end
endmodule // test_ses_status_top
